/* File: hdl/fec_harness_consts.vh */
// constants for the encoder/decoder self-test harness
// assumes nothing; definitions only
`ifndef FEC_HARNESS_CONSTS_VH
`define FEC_HARNESS_CONSTS_VH

`define STAT_WIDTH 32
`define CODE_WIDTH 8
`define BLOCK_WIDTH 66
`define CW_BLOCKS 32
`define BIST_CODEWORDS 32'h000186a0
`define ALIGN_TIMEOUT 32'h00030d40
`define HDR_UNCORR 2'h3
`define CODE_OK 8'h00
`define CODE_ALIGN 8'h01
`define CODE_DATA 8'h02
`define CODE_UNCORR 8'h03
`define CODE_NOCW 8'h04
`define PRBS_SEED 32'hffffffff

`endif

/* File: hdl/pulse_edge.v */
// rising and falling edge detector for a synchronous level
// assumes the input is already synchronous to mclk
`timescale 1ns/100ps
module pulse_edge (
  input wire mclk,
  input wire rst_n,
  input wire level,
  output wire rise,
  output wire fall
);
  reg level_q;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= 1'b0;
    end else begin
      level_q <= level;
    end
  end

  assign rise = level & ~level_q;
  assign fall = ~level & level_q;
endmodule // pulse_edge

/* File: hdl/stat_counter.v */
// saturating-free statistics counter with synchronous clear
// assumes clear and inc are single-cycle synchronous strobes
`timescale 1ns/100ps
module stat_counter #(
  parameter WIDTH = 32
) (
  input wire mclk,
  input wire rst_n,
  input wire clear,
  input wire inc,
  output reg [WIDTH-1:0] count
);
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count <= {WIDTH{1'b0}};
    end else if (clear) begin
      count <= {WIDTH{1'b0}};
    end else if (inc) begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule // stat_counter

/* File: hdl/fec_selftest_harness.v */
// self-checking harness around a forward error correction codec
// assumes codec and transceiver ports are synchronous to mclk
`timescale 1ns/100ps
`include "fec_harness_consts.vh"

// Summary of operation
// - one start pulse launches the built-in self-test sequence.
// - separate running, passed and failed status outputs.
// - 8-bit error code, reads zero after a passing self-test.
// - indication enable drives decoder enable input directly.
// - each uncorrectable-inject pulse corrupts one codeword beyond repair.
// - each correctable-inject pulse inserts one correctable error.
// - slip-inject pulse slips the receive gearbox to test realignment.
// - 32-bit count of every decoded codeword.
// - 32-bit count of error-free decoded codewords.
// - 32-bit count of codewords with correctable errors.
// - 32-bit count of codewords with uncorrectable errors.
// - 32-bit count of data checker mismatches.
// - 32-bit count of falling edges of decoder alignment.
// - statistics-clear pulse zeroes every statistics counter.
// - decoder aligned status mirrored onto a status output.
// - checker-locked status once checker locks to decoded data.
// - separate receive and transmit transceiver reset-done flags.
// - global reset control high holds the harness in reset.
// - self-test runs many codewords through encoder, decoder, checks them.
// - with indication enabled, uncorrectable headers marked 11.
module fec_selftest_harness #(
  parameter BIST_CODEWORDS = `BIST_CODEWORDS,
  parameter ALIGN_TIMEOUT = `ALIGN_TIMEOUT,
  parameter LOCK_COUNT = 8
) (
  input wire mclk,
  input wire rst_n,
  // operator controls
  input wire harnessReset,
  input wire selfTestStart,
  input wire indicationEnable,
  input wire injectUncorrectable,
  input wire injectCorrectable,
  input wire injectSlip,
  input wire statisticsClear,
  input wire loopbackSelect,
  // operator status
  output reg selfTestRunning,
  output reg selfTestPassed,
  output reg selfTestFailed,
  output reg [`CODE_WIDTH-1:0] selfTestCode,
  output reg [`STAT_WIDTH-1:0] codewordTotal,
  output reg [`STAT_WIDTH-1:0] codewordClean,
  output reg [`STAT_WIDTH-1:0] codewordCorrected,
  output reg [`STAT_WIDTH-1:0] codewordUncorrected,
  output reg [`STAT_WIDTH-1:0] dataMismatches,
  output reg [`STAT_WIDTH-1:0] alignmentLosses,
  output reg alignedMirror,
  output reg checkerLocked,
  output reg transceiver_receive_reset_done,
  output reg transceiver_transmit_reset_done,
  // encoder side
  output reg [`BLOCK_WIDTH-1:0] encDataIn,
  output reg encStart,
  input wire [`BLOCK_WIDTH-1:0] encDataOut,
  input wire encStartOut,
  // link towards the transceiver
  output reg [`BLOCK_WIDTH-1:0] linkTxData,
  output reg gearboxSlip,
  output reg transceiverLoopback,
  output reg transceiverReset,
  input wire gtRxResetDone,
  input wire gtTxResetDone,
  input wire decSlipRequest,
  // decoder side
  output wire decIndicationEnable,
  output reg decReset,
  input wire [`BLOCK_WIDTH-1:0] decDataOut,
  input wire decStartOut,
  input wire decAligned,
  input wire decCwInc,
  input wire decCwCorrected,
  input wire decCwUncorrected
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_IDLE = 2'd0;
  localparam ST_ALIGN = 2'd1;
  localparam ST_RUN = 2'd2;
  localparam ST_DONE = 2'd3;

  reg [1:0] state_q;
  reg [31:0] timer_q;
  reg [31:0] cwSeen_q;
  reg [31:0] genPrbs_q;
  reg [31:0] chkPrbs_q;
  reg [3:0] lockCnt_q;
  reg sawUncorr_q;
  reg injCorrPend_q;
  reg injUncorrPend_q;
  reg [4:0] injBlock_q;
  reg hrst_q;

  wire startRise;
  wire alignFall;
  wire incCorrRise;
  wire incUncorrRise;
  wire slipRise;
  wire clrRise;
  wire anyMismatch;
  wire [31:0] genNext;
  wire [31:0] chkNext;
  wire [`STAT_WIDTH-1:0] cTot;
  wire [`STAT_WIDTH-1:0] cClean;
  wire [`STAT_WIDTH-1:0] cCorr;
  wire [`STAT_WIDTH-1:0] cUnc;
  wire [`STAT_WIDTH-1:0] cMis;
  wire [`STAT_WIDTH-1:0] cLoss;
  wire hr_n;

  // ----------------------------------------
  // global reset
  // ----------------------------------------
  // operator reset holds all
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hrst_q <= 1'b1;
    end else begin
      hrst_q <= harnessReset;
    end
  end
  assign hr_n = rst_n & ~hrst_q;

  // ----------------------------------------
  // edge detection of operator pulses and of decoder alignment
  // ----------------------------------------
  // start pulse edge
  pulse_edge startEdge (.mclk(mclk), .rst_n(hr_n), .level(selfTestStart),
    .rise(startRise), .fall());
  pulse_edge corrEdge (.mclk(mclk), .rst_n(hr_n), .level(injectCorrectable),
    .rise(incCorrRise), .fall());
  pulse_edge uncEdge (.mclk(mclk), .rst_n(hr_n), .level(injectUncorrectable),
    .rise(incUncorrRise), .fall());
  pulse_edge slipEdge (.mclk(mclk), .rst_n(hr_n), .level(injectSlip),
    .rise(slipRise), .fall());
  pulse_edge clrEdge (.mclk(mclk), .rst_n(hr_n), .level(statisticsClear),
    .rise(clrRise), .fall());
  pulse_edge alignEdge (.mclk(mclk), .rst_n(hr_n), .level(decAligned),
    .rise(), .fall(alignFall));

  assign decIndicationEnable = indicationEnable;

  // ----------------------------------------
  // data generator
  // ----------------------------------------
  // prbs31 keeps every codeword distinct so slips show up
  assign genNext = {genPrbs_q[30:0], genPrbs_q[30] ^ genPrbs_q[27]};
  assign chkNext = {chkPrbs_q[30:0], chkPrbs_q[30] ^ chkPrbs_q[27]};

  always @(posedge mclk or negedge hr_n) begin
    if (!hr_n) begin
      genPrbs_q <= `PRBS_SEED;
      encDataIn <= {`BLOCK_WIDTH{1'b0}};
      encStart <= 1'b0;
    end else begin
      genPrbs_q <= genNext;
      encDataIn <= {genPrbs_q, genNext, 2'h1};
      encStart <= 1'b0;
    end
  end

  // ----------------------------------------
  // error injection and link
  // ----------------------------------------
  // injection waits for a codeword boundary so exactly one codeword is hit
  always @(posedge mclk or negedge hr_n) begin
    if (!hr_n) begin
      injCorrPend_q <= 1'b0;
      injUncorrPend_q <= 1'b0;
      injBlock_q <= 5'h00;
      linkTxData <= {`BLOCK_WIDTH{1'b0}};
    end else begin
      injBlock_q <= encStartOut ? 5'h01 : injBlock_q + 5'h01;
      linkTxData <= encDataOut;
      if (injCorrPend_q && encStartOut) begin
        linkTxData <= encDataOut ^ {{(`BLOCK_WIDTH-4){1'b0}}, 4'hf};
        injCorrPend_q <= incCorrRise;
      end else if (incCorrRise) begin
        injCorrPend_q <= 1'b1;
      end
      if (injUncorrPend_q && encStartOut) begin
        linkTxData <= encDataOut ^ {4'hf, {(`BLOCK_WIDTH-8){1'b0}}, 4'hf};
        injUncorrPend_q <= incUncorrRise;
      end else if (incUncorrRise) begin
        injUncorrPend_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // transceiver control
  // ----------------------------------------
  always @(posedge mclk or negedge hr_n) begin
    if (!hr_n) begin
      gearboxSlip <= 1'b0;
      transceiverLoopback <= 1'b1;
      transceiverReset <= 1'b1;
      decReset <= 1'b1;
      alignedMirror <= 1'b0;
      transceiver_receive_reset_done <= 1'b0;
      transceiver_transmit_reset_done <= 1'b0;
    end else begin
      gearboxSlip <= decSlipRequest | slipRise;
      transceiverLoopback <= loopbackSelect;
      transceiverReset <= 1'b0;
      decReset <= ~(gtRxResetDone & gtTxResetDone);
      alignedMirror <= decAligned;
      transceiver_receive_reset_done <= gtRxResetDone;
      transceiver_transmit_reset_done <= gtTxResetDone;
    end
  end

  // ----------------------------------------
  // data checker
  // ----------------------------------------
  // checker reseeds from the decoded word, then predicts the next one
  assign anyMismatch = checkerLocked && decAligned &&
    (decDataOut[65:34] != chkPrbs_q) &&
    !(indicationEnable && decDataOut[1:0] == `HDR_UNCORR);

  always @(posedge mclk or negedge hr_n) begin
    if (!hr_n) begin
      chkPrbs_q <= 32'h00000000;
      lockCnt_q <= 4'h0;
      checkerLocked <= 1'b0;
    end else if (!decAligned) begin
      lockCnt_q <= 4'h0;
      checkerLocked <= 1'b0;
    end else begin
      chkPrbs_q <= decDataOut[33:2];
      if (!checkerLocked) begin
        if (decDataOut[65:34] == chkPrbs_q) begin
          lockCnt_q <= lockCnt_q + 4'h1;
        end else begin
          lockCnt_q <= 4'h0;
        end
        checkerLocked <= (lockCnt_q == LOCK_COUNT[3:0]);
      end
    end
  end

  // ----------------------------------------
  // statistics counters
  // ----------------------------------------
  // total codewords
  stat_counter #(.WIDTH(`STAT_WIDTH)) totCnt (.mclk(mclk), .rst_n(hr_n),
    .clear(clrRise), .inc(decCwInc), .count(cTot));
  stat_counter #(.WIDTH(`STAT_WIDTH)) cleanCnt (.mclk(mclk), .rst_n(hr_n),
    .clear(clrRise), .inc(decCwInc & ~decCwCorrected & ~decCwUncorrected),
    .count(cClean));
  stat_counter #(.WIDTH(`STAT_WIDTH)) corrCnt (.mclk(mclk), .rst_n(hr_n),
    .clear(clrRise), .inc(decCwInc & decCwCorrected), .count(cCorr));
  stat_counter #(.WIDTH(`STAT_WIDTH)) uncCnt (.mclk(mclk), .rst_n(hr_n),
    .clear(clrRise), .inc(decCwInc & decCwUncorrected), .count(cUnc));
  stat_counter #(.WIDTH(`STAT_WIDTH)) misCnt (.mclk(mclk), .rst_n(hr_n),
    .clear(clrRise), .inc(anyMismatch), .count(cMis));
  stat_counter #(.WIDTH(`STAT_WIDTH)) lossCnt (.mclk(mclk), .rst_n(hr_n),
    .clear(clrRise), .inc(alignFall), .count(cLoss));

  // outputs registered so probe reads never see a combinational path
  always @(posedge mclk or negedge hr_n) begin
    if (!hr_n) begin
      codewordTotal <= {`STAT_WIDTH{1'b0}};
      codewordClean <= {`STAT_WIDTH{1'b0}};
      codewordCorrected <= {`STAT_WIDTH{1'b0}};
      codewordUncorrected <= {`STAT_WIDTH{1'b0}};
      dataMismatches <= {`STAT_WIDTH{1'b0}};
      alignmentLosses <= {`STAT_WIDTH{1'b0}};
    end else begin
      codewordTotal <= cTot;
      codewordClean <= cClean;
      codewordCorrected <= cCorr;
      codewordUncorrected <= cUnc;
      dataMismatches <= cMis;
      alignmentLosses <= cLoss;
    end
  end

  // ----------------------------------------
  // self-test sequencer
  // ----------------------------------------
  always @(posedge mclk or negedge hr_n) begin
    if (!hr_n) begin
      state_q <= ST_IDLE;
      timer_q <= 32'h00000000;
      cwSeen_q <= 32'h00000000;
      sawUncorr_q <= 1'b0;
      selfTestRunning <= 1'b0;
      selfTestPassed <= 1'b0;
      selfTestFailed <= 1'b0;
      selfTestCode <= `CODE_OK;
    end else begin
      case (state_q)
        ST_IDLE, ST_DONE: begin
          if (startRise) begin
            selfTestPassed <= 1'b0;
            selfTestFailed <= 1'b0;
            selfTestCode <= `CODE_OK;
            selfTestRunning <= 1'b1;
            timer_q <= 32'h00000000;
            cwSeen_q <= 32'h00000000;
            sawUncorr_q <= 1'b0;
            state_q <= ST_ALIGN;
          end
        end
        ST_ALIGN: begin
          timer_q <= timer_q + 32'h00000001;
          if (checkerLocked) begin
            timer_q <= 32'h00000000;
            state_q <= ST_RUN;
          end else if (timer_q == ALIGN_TIMEOUT) begin
            selfTestRunning <= 1'b0;
            selfTestFailed <= 1'b1;
            selfTestCode <= `CODE_ALIGN;
            state_q <= ST_DONE;
          end
        end
        ST_RUN: begin
          timer_q <= timer_q + 32'h00000001;
          if (decCwInc) begin
            cwSeen_q <= cwSeen_q + 32'h00000001;
          end
          if (decCwInc && decCwUncorrected && !injUncorrPend_q) begin
            sawUncorr_q <= 1'b1;
          end
          if (anyMismatch || !decAligned) begin
            selfTestRunning <= 1'b0;
            selfTestFailed <= 1'b1;
            selfTestCode <= decAligned ? `CODE_DATA : `CODE_ALIGN;
            state_q <= ST_DONE;
          end else if (sawUncorr_q) begin
            selfTestRunning <= 1'b0;
            selfTestFailed <= 1'b1;
            selfTestCode <= `CODE_UNCORR;
            state_q <= ST_DONE;
          end else if (timer_q == ALIGN_TIMEOUT && cwSeen_q == 32'h00000000) begin
            selfTestRunning <= 1'b0;
            selfTestFailed <= 1'b1;
            selfTestCode <= `CODE_NOCW;
            state_q <= ST_DONE;
          end else if (cwSeen_q == BIST_CODEWORDS) begin
            selfTestRunning <= 1'b0;
            selfTestPassed <= 1'b1;
            selfTestCode <= `CODE_OK;
            state_q <= ST_DONE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // fec_selftest_harness

/* File: tb/fec_harness_sva.sv */
// checker for the harness ports, bound to the harness
// assumes one clock mclk and the active-low reset rst_n
`timescale 1ns/100ps
module fec_harness_sva (
  input logic mclk,
  input logic rst_n,
  input logic harnessReset,
  input logic selfTestStart,
  input logic indicationEnable,
  input logic statisticsClear,
  input logic selfTestRunning,
  input logic selfTestPassed,
  input logic selfTestFailed,
  input logic [7:0] selfTestCode,
  input logic [31:0] alignmentLosses,
  input logic alignedMirror,
  input logic transceiver_receive_reset_done,
  input logic decIndicationEnable,
  input logic decReset,
  input logic decAligned,
  input logic gtRxResetDone
);
  // ------------
  // properties
  // ------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  chk_ind_direct: assert property (decIndicationEnable == indicationEnable)
    else $error("indication enable not passed through");
  chk_pass_excl: assert property (!(selfTestPassed && selfTestFailed))
    else $error("pass and fail together");
  chk_pass_code: assert property (selfTestPassed |-> selfTestCode == 8'h00)
    else $error("nonzero code with pass");
  chk_start_clear: assert property ($rose(selfTestStart) && !selfTestRunning
    && !harnessReset |=> selfTestRunning && !selfTestPassed && !selfTestFailed
    && selfTestCode == 8'h00)
    else $error("start did not launch a clean run");
  chk_mirror_rise: assert property ($rose(alignedMirror) |-> $past(decAligned))
    else $error("mirror rose without alignment");
  chk_rx_done: assert property ($rose(gtRxResetDone) && !harnessReset
    |=> transceiver_receive_reset_done)
    else $error("receive reset done not reported");
  chk_loss_count: assert property ($fell(decAligned) && !decReset && !harnessReset
    |-> ##[1:6] $changed(alignmentLosses))
    else $error("alignment loss not counted");
  chk_clear_zero: assert property ($rose(statisticsClear)
    |-> ##[1:4] alignmentLosses == 32'h0)
    else $error("clear left loss count");
endmodule // fec_harness_sva

bind fec_selftest_harness fec_harness_sva chk (
  .mclk, .rst_n, .harnessReset, .selfTestStart, .indicationEnable, .statisticsClear,
  .selfTestRunning, .selfTestPassed, .selfTestFailed, .selfTestCode, .alignmentLosses,
  .alignedMirror, .transceiver_receive_reset_done, .decIndicationEnable, .decReset,
  .decAligned, .gtRxResetDone);

/* File: tb/fec_codec_model.sv */
// behavioural codec and transceiver facing the harness
// assumes one clock mclk; encoding modelled as identity, 32 blocks a codeword
`timescale 1ns/100ps
module fec_codec_model (
  input wire mclk,
  input wire rst_n,
  input wire [65:0] encDataIn,
  output reg [65:0] encDataOut,
  output reg encStartOut,
  input wire [65:0] linkTxData,
  input wire gearboxSlip,
  input wire transceiverReset,
  output reg gtRxResetDone,
  output reg gtTxResetDone,
  output wire decSlipRequest,
  input wire decIndicationEnable,
  input wire decReset,
  output reg [65:0] decDataOut,
  output reg decStartOut,
  output reg decAligned,
  output reg decCwInc,
  output reg decCwCorrected,
  output reg decCwUncorrected
);
  reg [4:0] pos;
  reg [3:0] rstCnt;
  reg [5:0] alignCnt;
  reg [65:0] encPrev;
  reg bad, hard;
  // errors seen as difference from what was encoded
  wire [65:0] diff = linkTxData ^ encPrev;
  assign decSlipRequest = 1'b0;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {pos, rstCnt, alignCnt, encPrev, bad, hard} <= '0;
      {encDataOut, encStartOut, gtRxResetDone, gtTxResetDone} <= '0;
      {decDataOut, decStartOut, decAligned, decCwInc, decCwCorrected, decCwUncorrected} <= '0;
    end else begin
      pos <= pos + 5'h01;
      encDataOut <= encDataIn;
      encStartOut <= pos == 5'h1f;
      encPrev <= encDataOut;
      rstCnt <= transceiverReset ? 4'h0 : rstCnt + {3'h0, rstCnt != 4'hf};
      gtTxResetDone <= rstCnt > 4'h9;
      gtRxResetDone <= rstCnt > 4'hc;
      alignCnt <= (decReset || gearboxSlip) ? 6'h00 : alignCnt + {5'h0, alignCnt != 6'h3f};
      decAligned <= alignCnt == 6'h3f;
      decStartOut <= encStartOut;
      bad <= (decStartOut ? 1'b0 : bad) | (|diff);
      hard <= (decStartOut ? 1'b0 : hard) | (|diff[65:62]);
      decCwInc <= decStartOut && decAligned;
      decCwCorrected <= decStartOut && decAligned && bad && !hard;
      decCwUncorrected <= decStartOut && decAligned && hard;
      if (!decAligned)
        decDataOut <= ~decDataOut;
      else if (|diff[65:62])
        decDataOut <= decIndicationEnable ? {linkTxData[65:2], 2'h3} : linkTxData;
      else
        decDataOut <= encPrev;
    end
  end
endmodule // fec_codec_model

/* File: tb/testbench.sv */
// self-checking bench: driver notes expectations, monitor compares
// assumes the behavioural codec partner and the bound checker
`timescale 1ns/100ps
module testbench;
  reg mclk = 0, rst_n = 0, harnessReset = 0, indicationEnable = 0, loopbackSelect = 1;
  reg [4:0] kick = 5'h00;
  wire selfTestStart = kick[0], injectCorrectable = kick[1], injectUncorrectable = kick[2],
    injectSlip = kick[3], statisticsClear = kick[4];
  wire selfTestRunning, selfTestPassed, selfTestFailed, alignedMirror, checkerLocked;
  wire transceiver_receive_reset_done, transceiver_transmit_reset_done, encStart, encStartOut;
  wire gearboxSlip, transceiverLoopback, transceiverReset, gtRxResetDone, gtTxResetDone;
  wire decSlipRequest, decIndicationEnable, decReset, decStartOut, decAligned;
  wire decCwInc, decCwCorrected, decCwUncorrected;
  wire [7:0] selfTestCode;
  wire [31:0] codewordTotal, codewordClean, codewordCorrected, codewordUncorrected;
  wire [31:0] dataMismatches, alignmentLosses;
  wire [65:0] encDataIn, encDataOut, linkTxData, decDataOut;
  integer fail_count = 0, cmp_count = 0, seed = 33, i, k;
  logic [31:0] v, c, m;
  typedef struct {string n; int id; logic [31:0] e;} note_t;
  note_t q[$];
  note_t nt;
  wire [0:14][31:0] obs = {{31'h0, selfTestRunning}, {31'h0, selfTestPassed},
    {31'h0, selfTestFailed}, {31'h0, checkerLocked}, {31'h0, alignedMirror},
    {31'h0, transceiver_receive_reset_done}, {31'h0, transceiver_transmit_reset_done},
    {31'h0, decIndicationEnable}, {24'h0, selfTestCode}, codewordTotal, codewordClean,
    codewordCorrected, codewordUncorrected, alignmentLosses, dataMismatches};

  fec_selftest_harness #(.BIST_CODEWORDS(20), .ALIGN_TIMEOUT(200)) uut (
    .mclk, .rst_n, .harnessReset, .selfTestStart, .indicationEnable, .injectUncorrectable,
    .injectCorrectable, .injectSlip, .statisticsClear, .loopbackSelect, .selfTestRunning,
    .selfTestPassed, .selfTestFailed, .selfTestCode, .codewordTotal, .codewordClean,
    .codewordCorrected, .codewordUncorrected, .dataMismatches, .alignmentLosses,
    .alignedMirror, .checkerLocked, .transceiver_receive_reset_done,
    .transceiver_transmit_reset_done, .encDataIn, .encStart, .encDataOut, .encStartOut,
    .linkTxData, .gearboxSlip, .transceiverLoopback, .transceiverReset, .gtRxResetDone,
    .gtTxResetDone, .decSlipRequest, .decIndicationEnable, .decReset, .decDataOut,
    .decStartOut, .decAligned, .decCwInc, .decCwCorrected, .decCwUncorrected);
  fec_codec_model partner (
    .mclk, .rst_n, .encDataIn, .encDataOut, .encStartOut, .linkTxData, .gearboxSlip,
    .transceiverReset, .gtRxResetDone, .gtTxResetDone, .decSlipRequest,
    .decIndicationEnable, .decReset, .decDataOut, .decStartOut, .decAligned, .decCwInc,
    .decCwCorrected, .decCwUncorrected);

  task note(input string n, input int id, input logic [31:0] e);
    q.push_back('{n, id, e});
  endtask
  task cmp_flag(input string n, input logic e, input logic s);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %b seen %b", n, e, s);
    end
  endtask
  task cmp_word(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %0d seen %0d", n, e, s);
    end
  endtask
  // one-cycle pulse; a low cycle always follows
  task pulse(input int s);
    @(negedge mclk);
    kick[s] = 1'b1;
    @(negedge mclk);
    kick[s] = 1'b0;
  endtask
  task wait_chg(input int id, input logic [31:0] old, input int lim);
    for (k = 0; k < lim && obs[id] === old; k++) @(negedge mclk);
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // single bench clock stands in for both system clocks
  initial forever #12.5 mclk = ~mclk;
  initial forever begin
    wait (q.size() > 0);
    nt = q.pop_front();
    v = obs[nt.id];
    if (nt.id < 8)
      cmp_flag(nt.n, nt.e[0], v[0]);
    else
      cmp_word(nt.n, nt.e, v);
  end
  // whole run is under 2000 cycles; twice that is a hang
  initial begin
    #100000;
    fail_count++;
    $display("watchdog expired");
    give_verdict;
  end
  initial begin
    repeat (12) @(negedge mclk);
    rst_n = 1;
    @(negedge mclk);
    note("total", 9, 32'h0);
    note("running", 0, 32'h0);
    wait_chg(5, 32'h0, 100);
    note("rxdone", 5, 32'h1);
    note("txdone", 6, 32'h1);
    $display("test reset finished");
    for (i = 0; i < 8; i++) begin
      @(negedge mclk);
      c = $random(seed);
      indicationEnable = c[0];
      #1;
      note("ind", 7, {31'h0, c[0]});
    end
    indicationEnable = 1'b0;
    $display("test indication finished");
    wait_chg(3, 32'h0, 400);
    note("locked", 3, 32'h1);
    note("mirror", 4, 32'h1);
    pulse(0);
    note("running", 0, 32'h1);
    note("passed", 1, 32'h0);
    wait_chg(0, 32'h1, 3000);
    note("passed", 1, 32'h1);
    note("failed", 2, 32'h0);
    note("code", 8, 32'h0);
    $display("test self-test finished");
    @(posedge decCwInc);
    repeat (8) @(negedge mclk);
    pulse(4);
    repeat (5) @(negedge mclk);
    note("total", 9, 32'h0);
    note("loss", 13, 32'h0);
    repeat (4) @(posedge decCwInc);
    repeat (5) @(negedge mclk);
    note("total", 9, 32'h4);
    note("clean", 10, 32'h4);
    $display("test statistics finished");
    c = codewordCorrected;
    pulse(1);
    wait_chg(11, c, 200);
    note("corr", 11, c + 32'h1);
    c = codewordUncorrected;
    m = dataMismatches;
    pulse(2);
    wait_chg(12, c, 200);
    note("uncorr", 12, c + 32'h1);
    // hit word and the word after it both disagree with the prediction
    note("mismatch", 14, m + 32'h2);
    $display("test injection finished");
    c = alignmentLosses;
    pulse(3);
    wait_chg(13, c, 200);
    note("loss", 13, c + 32'h1);
    wait_chg(4, 32'h0, 200);
    note("mirror", 4, 32'h1);
    note("loss", 13, c + 32'h1);
    $display("test slip finished");
    wait_chg(3, 32'h0, 200);
    pulse(0);
    pulse(3);
    wait_chg(0, 32'h1, 200);
    note("failed", 2, 32'h1);
    note("passed", 1, 32'h0);
    note("code", 8, 32'h1);
    $display("test self-test fail finished");
    harnessReset = 1'b1;
    repeat (3) @(negedge mclk);
    note("total", 9, 32'h0);
    note("rxdone", 5, 32'h0);
    harnessReset = 1'b0;
    repeat (3) @(negedge mclk);
    $display("test harness reset finished");
    give_verdict;
  end
endmodule // testbench
